/* File: mac_pkg.sv */
// constants, types and the behaviour list of the multiply-accumulate unit
// Operation
// - multiply two signed 16-bit operands, add the 32-bit product into 40-bit accumulator
// - operand one is high byte register with accumulator; two is high byte with B
// - build the 16x16 product from four 8x8 partial products, one per cycle
// - multiply-accumulate op (prefix, A4) takes nine clock cycles start to completion
// - operand registers stay unchanged; only the wide accumulator takes the result
// - carry equals result sign; overflow reports two's complement overflow
// - multiply-accumulate only sets overflow, never clears it
// - clear op (prefix, E4) zeroes all 40 accumulator bits within two cycles
// - left shift op (prefix, 23) shifts the whole accumulator left one bit
// - right shift op (prefix, 03) shifts right one bit keeping the sign
// - two-bit window select picks the byte pair seen at window high and low
// - byte multiply takes B unsigned when its sign bit is 0, signed when 1
// - byte multiply takes accumulator unsigned when its sign bit is 0, signed when 1
// - the two sign-select bits never affect the multiply-accumulate
// - each data pointer has a circular-buffer enable bit
// - with index disable set, indexed code read uses the data pointer alone
// - configuration register at E2, resets to zero, byte access only
package mac_pkg;

   // ***************************************************************
   // widths and register map
   // ***************************************************************
   localparam int          ACC_W       = 40;
   localparam int          PROD_W      = 32;
   localparam int          PART_W      = 17;
   localparam logic [7:0]  ADDR_OP1_HI = 8'hE1;
   localparam logic [7:0]  ADDR_CFG    = 8'hE2;
   localparam logic [7:0]  ADDR_WIN_LO = 8'hE4;
   localparam logic [7:0]  ADDR_WIN_HI = 8'hE5;
   localparam logic [7:0]  ADDR_OP2_HI = 8'hF7;
   localparam logic [7:0]  CFG_RESET   = 8'h00;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;

   // ***************************************************************
   // configuration field positions
   // ***************************************************************
   localparam int CFG_WIN_HI   = 7;
   localparam int CFG_WIN_LO   = 6;
   localparam int CFG_SIGN_B   = 5;
   localparam int CFG_SIGN_A   = 4;
   localparam int CFG_CIRC1    = 3;
   localparam int CFG_CIRC0    = 2;
   localparam int CFG_IDX_DIS  = 1;
   localparam int CFG_REDIRECT = 0;

   // ***************************************************************
   // second opcode byte after the extended prefix, and cycle counts
   // ***************************************************************
   localparam logic [7:0] OPC_MAC = 8'hA4;
   localparam logic [7:0] OPC_CLR = 8'hE4;
   localparam logic [7:0] OPC_LSL = 8'h23;
   localparam logic [7:0] OPC_ASR = 8'h03;
   localparam logic [3:0] MAC_CYCLES = 4'h9;
   localparam logic [3:0] CLR_CYCLES = 4'h2;
   localparam logic [1:0] LAST_PART  = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_PART, ST_ADD, ST_WAIT} mac_state_t;

endpackage

/* File: mac_mul_if.sv */
// signals between the sequencer and the shared 8x8 multiplier
`timescale 1ns/10ps
interface mac_mul_if;
   logic [7:0]         a;
   logic [7:0]         b;
   logic               a_signed;
   logic               b_signed;
   logic signed [16:0] prod;
   modport user (output a, output b, output a_signed, output b_signed, input prod);
   modport unit (input a, input b, input a_signed, input b_signed, output prod);
endinterface

/* File: mac_mul8.sv */
// shared 8x8 multiplier with per-operand signedness
`timescale 1ns/10ps
module mac_mul8 (
   mac_mul_if.unit m
);
   logic signed [8:0]  a_ext;
   logic signed [8:0]  b_ext;
   logic signed [17:0] full;

   // extend each operand by its own sign only when it is to be taken signed
   assign a_ext = $signed({m.a_signed & m.a[7], m.a});
   assign b_ext = $signed({m.b_signed & m.b[7], m.b});
   assign full = a_ext * b_ext;
   // any mixed 8x8 product fits in 17 signed bits
   assign m.prod = full[16:0];
endmodule

/* File: mac_unit.sv */
// multiply-accumulate unit: wide accumulator, sequencer and register window
`timescale 1ns/10ps
module mac_unit
   import mac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   output logic             sfr_hit,
   input  wire logic [7:0]  acc_in,
   input  wire logic [7:0]  b_in,
   input  wire logic        op_start,
   input  wire logic [7:0]  op_code,
   input  wire logic        mul_start,
   input  wire logic        ov_in,
   input  wire logic [15:0] dptr_in,
   input  wire logic        dptr_sel_in,
   output logic             busy,
   output logic             done,
   output logic             flag_we,
   output logic             carry_out,
   output logic             ov_out,
   output logic      [15:0] mul_product,
   output logic      [15:0] code_addr,
   output logic             circ_active,
   output logic             move_use_b,
   output logic             pointer0_circular_enable,
   output logic             pointer1_circular_enable,
   output logic             code_read_index_disable,
   output logic             pointer1_redirect
);

   // ***************************************************************
   // state
   // ***************************************************************
   mac_state_t               state_reg;
   logic [7:0]               op1_hi_reg;
   logic [7:0]               op2_hi_reg;
   logic [7:0]               cfg_reg;
   logic [ACC_W-1:0]         macc_reg;
   logic [15:0]              opa_reg;
   logic [15:0]              opb_reg;
   logic signed [PROD_W-1:0] prod_reg;
   logic [1:0]               part_reg;
   logic [3:0]               cyc_reg;
   logic [3:0]               limit_reg;
   logic                     is_clear_reg;
   logic [ACC_W-1:0]         sum_reg;
   logic                     ovf_reg;

   mac_mul_if mul_bus ();

   mac_mul8 u_mul (
      .m (mul_bus)
   );

   // bit index of the lowest accumulator bit seen through the window
   function automatic int win_lsb(input logic [1:0] sel);
      return 8 * int'(sel);
   endfunction

   logic [1:0]  win_sel;
   logic        accept;
   logic        wr_ok;
   assign win_sel = cfg_reg[CFG_WIN_HI:CFG_WIN_LO];
   // new work only when nothing is running, so stalls cover every op
   assign accept = op_start && state_reg == ST_IDLE;
   // register writes are ignored while a sequence owns the accumulator
   assign wr_ok = sfr_wr && state_reg == ST_IDLE;

   // ***************************************************************
   // multiplier operand steering
   // ***************************************************************
   logic signed [PROD_W-1:0] part_ext;
   logic signed [PROD_W-1:0] part_add;
   always_comb begin
      mul_bus.a        = acc_in;
      mul_bus.b        = b_in;
      mul_bus.a_signed = cfg_reg[CFG_SIGN_A];
      mul_bus.b_signed = cfg_reg[CFG_SIGN_B];
      if (state_reg == ST_PART) begin
         // partials: lo*lo, hi*lo, lo*hi, hi*hi; only high bytes carry sign
         mul_bus.a        = part_reg[0] ? opa_reg[15:8] : opa_reg[7:0];
         mul_bus.b        = part_reg[1] ? opb_reg[15:8] : opb_reg[7:0];
         mul_bus.a_signed = part_reg[0];
         mul_bus.b_signed = part_reg[1];
      end
   end

   // align each partial product by its byte weight
   always_comb begin
      part_ext = PROD_W'(mul_bus.prod);
      unique case (part_reg)
         2'h0:    part_add = part_ext;
         2'h3:    part_add = part_ext <<< 16;
         default: part_add = part_ext <<< 8;
      endcase
   end

   // sign-extended product added into the accumulator
   logic [ACC_W-1:0] prod_wide;
   logic [ACC_W-1:0] sum_next;
   logic             ovf_next;
   assign prod_wide = {{(ACC_W-PROD_W){prod_reg[PROD_W-1]}}, prod_reg};
   assign sum_next = macc_reg + prod_wide;
   // overflow: both addends share a sign that the sum does not
   assign ovf_next = (macc_reg[ACC_W-1] == prod_wide[ACC_W-1])
                  && (sum_next[ACC_W-1] != macc_reg[ACC_W-1]);

   // ***************************************************************
   // sequencer
   // ***************************************************************
   // one state machine drives the partial product walk and the timing
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg    <= ST_IDLE;
         part_reg     <= 2'h0;
         cyc_reg      <= 4'h0;
         limit_reg    <= 4'h0;
         is_clear_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               cyc_reg  <= 4'h1;
               part_reg <= 2'h0;
               if (accept && op_code == OPC_MAC) begin
                  state_reg    <= ST_PART;
                  limit_reg    <= MAC_CYCLES - 4'h1;
                  is_clear_reg <= 1'b0;
               end else if (accept && op_code == OPC_CLR) begin
                  state_reg    <= ST_WAIT;
                  limit_reg    <= CLR_CYCLES - 4'h1;
                  is_clear_reg <= 1'b1;
               end
            end
            ST_PART: begin
               // one partial product per clock through the byte multiplier
               cyc_reg  <= cyc_reg + 4'h1;
               part_reg <= part_reg + 2'h1;
               if (part_reg == LAST_PART) begin
                  state_reg <= ST_ADD;
               end
            end
            ST_ADD: begin
               cyc_reg   <= cyc_reg + 4'h1;
               state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               cyc_reg <= cyc_reg + 4'h1;
               if (cyc_reg >= limit_reg) begin
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   logic finish;
   assign finish = state_reg == ST_WAIT && cyc_reg >= limit_reg;

   // ***************************************************************
   // operand capture and product build
   // ***************************************************************
   // operands are copied so the source registers are only ever read
   always_ff @(posedge clk) begin
      if (reset) begin
         opa_reg <= 16'h0000;
         opb_reg <= 16'h0000;
      end else if (accept && op_code == OPC_MAC) begin
         opa_reg <= {op1_hi_reg, acc_in};
         opb_reg <= {op2_hi_reg, b_in};
      end
   end

   // product register summed over the four partial cycles
   always_ff @(posedge clk) begin
      if (reset) begin
         prod_reg <= '0;
      end else if (accept) begin
         prod_reg <= '0;
      end else if (state_reg == ST_PART) begin
         prod_reg <= prod_reg + part_add;
      end
   end

   // sum and overflow are staged so the 40-bit add has a whole cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         sum_reg <= '0;
         ovf_reg <= 1'b0;
      end else if (state_reg == ST_ADD) begin
         sum_reg <= sum_next;
         ovf_reg <= ovf_next;
      end
   end

   // ***************************************************************
   // wide accumulator
   // ***************************************************************
   logic [ACC_W-1:0] macc_next;
   always_comb begin
      macc_next = macc_reg;
      if (finish && is_clear_reg) begin
         macc_next = '0;
      end else if (finish) begin
         macc_next = sum_reg;
      end else if (accept && op_code == OPC_LSL) begin
         macc_next = {macc_reg[ACC_W-2:0], 1'b0};
      end else if (accept && op_code == OPC_ASR) begin
         macc_next = {macc_reg[ACC_W-1], macc_reg[ACC_W-1:1]};
      end else if (wr_ok && sfr_addr == ADDR_WIN_LO) begin
         macc_next[win_lsb(win_sel) +: 8] = sfr_wdata;
      end else if (wr_ok && sfr_addr == ADDR_WIN_HI) begin
         macc_next[win_lsb(win_sel) + 8 +: 8] = sfr_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         macc_reg <= '0;
      end else begin
         macc_reg <= macc_next;
      end
   end

   // ***************************************************************
   // byte-wide registers
   // ***************************************************************
   // configuration is byte written only; no single-bit path exists
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_reg <= CFG_RESET;
      end else if (wr_ok && sfr_addr == ADDR_CFG) begin
         cfg_reg <= sfr_wdata;
      end
   end

   // operand high bytes
   always_ff @(posedge clk) begin
      if (reset) begin
         op1_hi_reg <= BYTE_ZERO;
         op2_hi_reg <= BYTE_ZERO;
      end else if (wr_ok) begin
         if (sfr_addr == ADDR_OP1_HI) begin
            op1_hi_reg <= sfr_wdata;
         end
         if (sfr_addr == ADDR_OP2_HI) begin
            op2_hi_reg <= sfr_wdata;
         end
      end
   end

   // read port: one cycle of latency, zero and no hit when unmapped
   always_ff @(posedge clk) begin
      if (reset) begin
         sfr_rdata <= BYTE_ZERO;
         sfr_hit   <= 1'b0;
      end else begin
         sfr_hit   <= 1'b0;
         sfr_rdata <= BYTE_ZERO;
         if (sfr_rd) begin
            sfr_hit <= 1'b1;
            unique case (sfr_addr)
               ADDR_OP1_HI: sfr_rdata <= op1_hi_reg;
               ADDR_OP2_HI: sfr_rdata <= op2_hi_reg;
               ADDR_CFG:    sfr_rdata <= cfg_reg;
               ADDR_WIN_LO: sfr_rdata <= macc_reg[win_lsb(win_sel) +: 8];
               ADDR_WIN_HI: sfr_rdata <= macc_reg[win_lsb(win_sel) + 8 +: 8];
               default:     sfr_hit <= 1'b0;
            endcase
         end
      end
   end

   // ***************************************************************
   // status to the core
   // ***************************************************************
   // busy rises the edge after a long op is taken and drops at its end
   always_ff @(posedge clk) begin
      if (reset) begin
         busy <= 1'b0;
      end else if (accept && (op_code == OPC_MAC || op_code == OPC_CLR)) begin
         busy <= 1'b1;
      end else if (finish) begin
         busy <= 1'b0;
      end
   end

   // done pulses once for every completed op, short or long
   always_ff @(posedge clk) begin
      if (reset) begin
         done <= 1'b0;
      end else begin
         done <= finish
              || (accept && (op_code == OPC_LSL || op_code == OPC_ASR))
              || (mul_start && state_reg == ST_IDLE && !op_start);
      end
   end

   // flags go back for the core to write; overflow can only be raised
   always_ff @(posedge clk) begin
      if (reset) begin
         flag_we   <= 1'b0;
         carry_out <= 1'b0;
         ov_out    <= 1'b0;
      end else begin
         flag_we <= finish && !is_clear_reg;
         if (finish && !is_clear_reg) begin
            carry_out <= sum_reg[ACC_W-1];
            ov_out    <= ov_in | ovf_reg;
         end
      end
   end

   // byte multiply: one cycle, signedness from the configuration bits
   always_ff @(posedge clk) begin
      if (reset) begin
         mul_product <= 16'h0000;
      end else if (mul_start && state_reg == ST_IDLE && !op_start) begin
         mul_product <= mul_bus.prod[15:0];
      end
   end

   // ***************************************************************
   // data pointer side controls
   // ***************************************************************
   // code address: index dropped when disabled, pointer alone is used
   always_ff @(posedge clk) begin
      if (reset) begin
         code_addr <= 16'h0000;
      end else if (cfg_reg[CFG_IDX_DIS]) begin
         code_addr <= dptr_in;
      end else begin
         code_addr <= dptr_in + {BYTE_ZERO, acc_in};
      end
   end

   // per-pointer mode bits; wrap arithmetic itself lives in the pointer unit
   always_ff @(posedge clk) begin
      if (reset) begin
         circ_active              <= 1'b0;
         move_use_b               <= 1'b0;
         pointer0_circular_enable <= 1'b0;
         pointer1_circular_enable <= 1'b0;
         code_read_index_disable  <= 1'b0;
         pointer1_redirect        <= 1'b0;
      end else begin
         circ_active <= dptr_sel_in ? cfg_reg[CFG_CIRC1] : cfg_reg[CFG_CIRC0];
         move_use_b  <= dptr_sel_in && cfg_reg[CFG_REDIRECT];
         pointer0_circular_enable <= cfg_reg[CFG_CIRC0];
         pointer1_circular_enable <= cfg_reg[CFG_CIRC1];
         code_read_index_disable  <= cfg_reg[CFG_IDX_DIS];
         pointer1_redirect        <= cfg_reg[CFG_REDIRECT];
      end
   end

endmodule

/* File: mac_unit_asserts.sv */
// assertion checker for the multiply-accumulate unit ports
`timescale 1ns/10ps
module mac_unit_asserts
   import mac_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        sfr_hit,
   input wire logic [7:0]  acc_in,
   input wire logic        op_start,
   input wire logic [7:0]  op_code,
   input wire logic        mul_start,
   input wire logic        ov_in,
   input wire logic [15:0] dptr_in,
   input wire logic        dptr_sel_in,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        flag_we,
   input wire logic        carry_out,
   input wire logic        ov_out,
   input wire logic [15:0] code_addr,
   input wire logic        move_use_b,
   input wire logic        code_read_index_disable,
   input wire logic        pointer1_redirect
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);

   // ********
   // request decode
   // ********
   // an op is only taken while the unit is not stalling the core
   logic go, mac_go, clr_go, sh_go, hit_go;
   assign go     = op_start && !busy;
   assign mac_go = go && op_code == OPC_MAC;
   assign clr_go = go && op_code == OPC_CLR;
   assign sh_go  = go && (op_code == OPC_LSL || op_code == OPC_ASR);
   assign hit_go = sfr_rd && (sfr_addr == ADDR_OP1_HI || sfr_addr == ADDR_CFG ||
      sfr_addr == ADDR_WIN_LO || sfr_addr == ADDR_WIN_HI || sfr_addr == ADDR_OP2_HI);

   // ********
   // assertions
   // ********
   mac_nine_a: assert property (mac_go |=> busy [*8] ##1 (!busy && done && flag_we))
      else $error("multiply-accumulate not done in nine cycles");
   clr_two_a: assert property (clr_go |=> busy ##1 (!busy && done && !flag_we))
      else $error("clear not done in two cycles");
   shift_done_a: assert property (sh_go |=> done && !busy)
      else $error("shift did not complete in one cycle");
   read_hit_a: assert property (hit_go |=> sfr_hit)
      else $error("mapped read not answered");
   read_miss_a: assert property (sfr_rd && !hit_go |=> !sfr_hit && sfr_rdata == BYTE_ZERO)
      else $error("unmapped read answered");
   bus_quiet_a: assert property (!sfr_rd |=> !sfr_hit && sfr_rdata == BYTE_ZERO)
      else $error("read bus active without a read");
   flag_hold_a: assert property (!flag_we |-> $stable(carry_out) && $stable(ov_out))
      else $error("flags moved without a flag strobe");
   ov_sticky_a: assert property (flag_we && ov_in |-> ov_out)
      else $error("overflow flag was cleared");
   code_addr_a: assert property ($stable(code_read_index_disable) && !$past(reset) |->
      code_addr == $past(dptr_in) + (code_read_index_disable ? 16'h0000 : {8'h00, $past(acc_in)}))
      else $error("code address wrong");
   redirect_a: assert property ($stable(pointer1_redirect) && !$past(reset) |->
      move_use_b == ($past(dptr_sel_in) && pointer1_redirect))
      else $error("move redirect wrong");

   mac_seen_c: cover property (mac_go);
   ovf_seen_c: cover property (flag_we && ov_out && !ov_in);
   mul_seen_c: cover property (mul_start && !busy ##1 done);
endmodule

bind mac_unit mac_unit_asserts i_chk (.clk, .reset, .sfr_addr, .sfr_rd, .sfr_rdata, .sfr_hit,
   .acc_in, .op_start, .op_code, .mul_start, .ov_in, .dptr_in, .dptr_sel_in, .busy, .done,
   .flag_we, .carry_out, .ov_out, .code_addr, .move_use_b, .code_read_index_disable,
   .pointer1_redirect);

/* File: mac_core_model.sv */
// model of the core registers that feed the multiply-accumulate unit
`timescale 1ns/10ps
module mac_core_model (
   input  wire logic        clk,
   input  wire logic        flag_we,
   input  wire logic        ov_out,
   output logic      [7:0]  acc_in,
   output logic      [7:0]  b_in,
   output logic             ov_in,
   output logic      [15:0] dptr_in,
   output logic             dptr_sel_in
);
   // ********
   // core registers
   // ********
   // the status word takes the flag result at the strobe edge, so a set flag feeds back
   always @(posedge clk) begin
      if (flag_we) begin
         ov_in <= ov_out;
      end
   end

   // core registers change only between instructions, at a falling edge
   task automatic load(input logic [7:0] a, b, input logic [15:0] dp, input logic sel);
      @(negedge clk);
      acc_in      <= a;
      b_in        <= b;
      dptr_in     <= dp;
      dptr_sel_in <= sel;
   endtask

   initial begin
      acc_in      = 8'h00;
      b_in        = 8'h00;
      ov_in       = 1'b0;
      dptr_in     = 16'h0000;
      dptr_sel_in = 1'b0;
   end
endmodule

/* File: test_multiply_accumulate_unit.sv */
// self-checking bench for the multiply-accumulate unit
`timescale 1ns/10ps
module test_multiply_accumulate_unit
   import mac_pkg::*;
;
   // ********
   // stimulus, reference model and result notes
   // ********
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        sfr_wr = 1'b0;
   logic        sfr_rd = 1'b0;
   logic        op_start = 1'b0;
   logic        mul_start = 1'b0;
   logic [7:0]  sfr_addr = 8'h00;
   logic [7:0]  sfr_wdata = 8'h00;
   logic [7:0]  op_code = 8'h00;
   logic [7:0]  sfr_rdata, acc_in, b_in;
   logic [15:0] dptr_in, mul_product, code_addr;
   logic        sfr_hit, ov_in, dptr_sel_in, busy, done, flag_we, carry_out, ov_out;
   logic        circ_active, move_use_b, code_read_index_disable, pointer1_redirect;
   logic        pointer0_circular_enable, pointer1_circular_enable;
   logic        rd_d = 1'b0;
   logic        mul_d = 1'b0;
   logic        ov_m = 1'b0;
   logic [39:0] m = 40'h00_0000_0000;
   logic [7:0]  cfg = CFG_RESET;
   logic [7:0]  ah = 8'h00;
   logic [7:0]  bh = 8'h00;
   logic [8:0]  rd_q[$];
   logic [15:0] mul_q[$];
   logic [1:0]  flg_q[$];
   logic [7:0]  ra[7] = '{ADDR_OP1_HI, ADDR_CFG, ADDR_WIN_LO, ADDR_WIN_HI, ADDR_OP2_HI,
                          8'hE3, 8'hF6};
   logic [15:0] wtab[8] = '{16'hE200, 16'hE4FF, 16'hE5FF, 16'hE280, 16'hE4FF, 16'hE5FF,
                            16'hE2C0, 16'hE57F};
   int          num_errors = 0;
   int          check_count = 0;
   int          seed = 32'h96ACC474;

   mac_unit i_dut (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
      .acc_in, .b_in, .op_start, .op_code, .mul_start, .ov_in, .dptr_in, .dptr_sel_in, .busy,
      .done, .flag_we, .carry_out, .ov_out, .mul_product, .code_addr, .circ_active, .move_use_b,
      .pointer0_circular_enable, .pointer1_circular_enable, .code_read_index_disable,
      .pointer1_redirect);
   mac_core_model i_core (.clk, .flag_we, .ov_out, .acc_in, .b_in, .ov_in, .dptr_in,
      .dptr_sel_in);

   // free-running system clock
   initial begin
      forever #5 clk = ~clk;
   end

   // ********
   // tasks
   // ********
   task automatic compare(input logic [15:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [8:0] exp_rd(input logic [7:0] a);
      case (a)
         ADDR_OP1_HI: return {1'b1, ah};
         ADDR_CFG:    return {1'b1, cfg};
         ADDR_WIN_LO: return {1'b1, m[8*cfg[7:6] +: 8]};
         ADDR_WIN_HI: return {1'b1, m[8*cfg[7:6]+8 +: 8]};
         ADDR_OP2_HI: return {1'b1, bh};
         default:     return {1'b0, BYTE_ZERO};
      endcase
   endfunction

   // one register access; a read notes its expected answer, a write updates the model
   task automatic sfr(input logic wr, input logic [7:0] a, d);
      if (!wr) begin
         rd_q.push_back(exp_rd(a));
      end else if (a == ADDR_OP1_HI) begin
         ah = d;
      end else if (a == ADDR_OP2_HI) begin
         bh = d;
      end else if (a == ADDR_CFG) begin
         cfg = d;
      end else if (a == ADDR_WIN_LO || a == ADDR_WIN_HI) begin
         m[8*cfg[7:6] + (a == ADDR_WIN_HI ? 8 : 0) +: 8] = d;
      end
      @(negedge clk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= wr;
      sfr_rd    <= !wr;
      @(negedge clk);
      sfr_wr    <= 1'b0;
      sfr_rd    <= 1'b0;
   endtask

   task automatic rdall;
      foreach (ra[i]) sfr(1'b0, ra[i], BYTE_ZERO);
   endtask

   task automatic rdwin;
      for (int n = 0; n < 4; n++) begin
         sfr(1'b1, ADDR_CFG, {n[1:0], 6'h00});
         sfr(1'b0, ADDR_WIN_LO, BYTE_ZERO);
         sfr(1'b0, ADDR_WIN_HI, BYTE_ZERO);
      end
   endtask

   // the latency is fixed per op, so done must be high exactly then
   task automatic op(input logic [7:0] code, input int lat);
      @(negedge clk);
      op_start <= 1'b1;
      op_code  <= code;
      @(negedge clk);
      op_start <= 1'b0;
      repeat (lat - 1) @(negedge clk);
      compare({14'h0000, done, busy}, 16'h0002, "op end");
   endtask

   task automatic mac(input logic [15:0] x, y);
      logic [31:0] p;
      logic [39:0] s;
      sfr(1'b1, ADDR_OP1_HI, x[15:8]);
      sfr(1'b1, ADDR_OP2_HI, y[15:8]);
      i_core.load(x[7:0], y[7:0], 16'($random(seed)), 1'($random(seed)));
      p = $signed(x) * $signed(y);
      s = m + {{8{p[31]}}, p};
      ov_m = ov_m | (m[39] == p[31] && s[39] != m[39]);
      m = s;
      flg_q.push_back({s[39], ov_m});
      op(OPC_MAC, 9);
   endtask

   task automatic mul(input logic [7:0] a, b);
      logic signed [17:0] p;
      i_core.load(a, b, dptr_in, dptr_sel_in);
      p = $signed({cfg[CFG_SIGN_A] & a[7], a}) * $signed({cfg[CFG_SIGN_B] & b[7], b});
      mul_q.push_back(p[15:0]);
      @(negedge clk);
      mul_start <= 1'b1;
      @(negedge clk);
      mul_start <= 1'b0;
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ********
   // result monitor: outputs sampled before the edge updates land
   // ********
   always @(posedge clk) begin
      rd_d  <= sfr_rd;
      mul_d <= mul_start;
      if (rd_d) compare({7'h00, sfr_hit, sfr_rdata}, {7'h00, rd_q.pop_front()}, "read");
      if (mul_d) compare(mul_product, mul_q.pop_front(), "byte product");
      if (flag_we) compare({14'h0000, carry_out, ov_out}, {14'h0000, flg_q.pop_front()}, "flags");
   end

   // ********
   // test sequence
   // ********
   initial begin
      repeat (4) @(negedge clk);
      reset <= 1'b0;
      rdall();
      $display("reset value test done");
      op(OPC_CLR, 2);
      for (int i = 0; i < 10; i++) begin
         sfr(1'b1, ADDR_CFG, 8'($random(seed)));
         @(negedge clk);
         compare({11'h000, circ_active, pointer1_circular_enable, pointer0_circular_enable,
            code_read_index_disable, pointer1_redirect},
            {11'h000, cfg[{1'b1, dptr_sel_in}], cfg[3:0]}, "config");
         mac(16'($random(seed)), 16'($random(seed)));
         rdwin();
      end
      mac(16'h8000, 16'h8000);
      rdall();
      $display("accumulate test done");
      // fill the accumulator to its positive limit through the window
      foreach (wtab[i]) sfr(1'b1, wtab[i][15:8], wtab[i][7:0]);
      mac(16'h7FFF, 16'h7FFF);
      mac(16'hFFFF, 16'h0001);
      $display("overflow test done");
      for (int i = 0; i < 3; i++) begin
         op(OPC_ASR, 1);
         m = {m[39], m[39:1]};
         op(OPC_LSL, 1);
         m = {m[38:0], 1'b0};
         rdwin();
      end
      $display("shift test done");
      for (int i = 0; i < 8; i++) begin
         sfr(1'b1, ADDR_CFG, {2'b00, i[1:0], 4'h0});
         mul(i < 4 ? 8'h80 : 8'($random(seed)), i < 4 ? 8'hFF : 8'($random(seed)));
      end
      $display("byte multiply test done");
      op(OPC_CLR, 2);
      m = '0;
      rdwin();
      $display("clear test done");
      print_verdict();
   end

   // ends a hang well past the run of under seven hundred cycles
   initial begin
      #200000;
      num_errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      print_verdict();
   end
endmodule
